// ### src/wbl_evaluator.sv
// work bit logic evaluator: eight configurable work bits behind APB
// assumes controller status on the same clock, event pins asynchronous,
// and one eval_i pulse per control cycle from the controller's sequencer
`timescale 1ns/100ps
`default_nettype none
// Notes on behaviour
// [R01] eight independent work bits, each with own operation, selectors, inversions
// [R02] no operation keeps a work bit off; it is the reset default
// [R03] operation 1: (A and B) or (C and D)
// [R04] operation 2: (A or C) and (B or D)
// [R05] operation 3: any of A, B, C, D
// [R06] operation 4: all of A, B, C, D
// [R07] codes 0, 1 constants; code 2 true for first evaluation after power-up
// [R08] codes 3 to 6 pick external event inputs 1 to 4
// [R09] codes 7 to 9 alarms; code 10 either output count alarm
// [R10] code 11 follows output 1, off if that output is linear
// [R11] code 12 follows output 2, off if absent or linear
// [R12] codes 13 to 17: input, remote setpoint, heater errors and alarms
// [R13] codes 18 to 20: manual, reset, hold
// [R14] codes 21 to 27: setpoint modes, autotuning, run, standby, wait
// [R15] codes 28 to 31: time signals, program end, stage
// [R16] codes 32 to 34 program bits, 35 reserved, 36 to 40 segment bits
// [R17] same code list everywhere; codes 41 to 48 feed back work bits
// [R18] each input has its own inversion flag
// [R19] each work bit has an output inversion flag
// [R20] work bits drive outputs and may change operating status
// [R21] in-use flag whenever any work bit has a real operation
// [R22] event data selector: 0 none, 1-4 event pins, 5-12 work bits
// [R23] all bits evaluated once per cycle from last cycle's work bits
module wbl_evaluator (
  input  wire logic                 clk_i,      // 100 MHz clock
  input  wire logic                 arst_n_i,   // async reset, active low
  // apb slave
  input  wire logic                 psel,       // slave select
  input  wire logic                 penable,    // access phase
  input  wire logic                 pwrite,     // write when high
  input  wire logic [7:0]           paddr,      // byte address
  input  wire logic [31:0]          pwdata,     // write data
  output logic                      pready,     // always ready
  output logic [31:0]               prdata,     // registered read data
  output logic                      pslverr,    // unmapped access
  // controller side
  input  wire logic                 eval_i,     // one pulse per cycle
  input  wire logic [3:0]           event_i,    // event pins, async
  input  wire wbl_pkg::wbl_status_t status_i,   // controller status
  output logic [7:0]                work_bits_o,  // registered work bits
  output logic [3:0]                event_data_o, // resolved event data
  output logic                      in_use_o      // display dot
);
  import wbl_pkg::*;

  // configuration state
  wbl_cfg_t   cfg_r [WBL_NUM_WB];
  logic [15:0] evsrc_r;
  logic [2:0]  hwcfg_r;

  // evaluation state
  logic [7:0]  work_bit_r;
  logic [7:0]  result;
  logic        pwrup_r;
  logic        in_use_r;
  logic [3:0]  event_data_r;

  // pin synchronisers
  logic [3:0]  ev_meta_r;
  logic [3:0]  ev_sync_r;

  // source vector and bus decode
  logic [63:0] src_vec;
  logic        setup_ph;
  logic        access_ph;
  logic        hit;
  logic        cfg_hit;
  logic [2:0]  cfg_idx;
  logic [31:0] rd_val;

  // event pins are asynchronous; two flops before any use
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      ev_meta_r <= 4'h0;
      ev_sync_r <= 4'h0;
    end else begin
      ev_meta_r <= event_i;
      ev_sync_r <= ev_meta_r;
    end
  end

  // bus phases
  assign setup_ph  = psel & ~penable;
  assign access_ph = psel & penable;

  // address decode
  always_comb begin
    cfg_idx = paddr[4:2];
    cfg_hit = 1'b0;
    hit     = 1'b0;
    if (paddr[1:0] != 2'b00) begin
      hit = 1'b0;
    end else if (paddr <= WBL_CFG_LAST) begin
      cfg_hit = 1'b1;
      hit     = 1'b1;
    end else if (paddr == WBL_STAT_OFF) begin
      hit = 1'b1;
    end else if (paddr == WBL_EVSRC_OFF) begin
      hit = 1'b1;
    end else if (paddr == WBL_HWCFG_OFF) begin
      hit = 1'b1;
    end
  end

  // zero wait states; read data was latched in the setup cycle
  assign pready  = 1'b1;
  assign pslverr = access_ph & ~hit;
  assign prdata  = rd_val;

  // [R01] per work bit setup words
  // [R02] reset leaves every work bit at no operation
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      for (int i = 0; i < WBL_NUM_WB; i++) begin
        cfg_r[i] <= WBL_CFG_RST;
      end
    end else if (access_ph && pwrite && cfg_hit) begin
      cfg_r[cfg_idx] <= pwdata;
    end
  end

  // event data selectors and output type straps
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      evsrc_r <= WBL_EVSRC_RST;
      hwcfg_r <= WBL_HWCFG_RST;
    end else if (access_ph && pwrite) begin
      if (paddr == WBL_EVSRC_OFF) begin
        evsrc_r <= pwdata[15:0];
      end else if (paddr == WBL_HWCFG_OFF) begin
        hwcfg_r <= pwdata[2:0];
      end
    end
  end

  // read data captured at setup so it comes from a flop
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      rd_val <= 32'h0000_0000;
    end else if (setup_ph && !pwrite) begin
      if (cfg_hit) begin
        rd_val <= cfg_r[cfg_idx];
      end else if (paddr == WBL_STAT_OFF) begin
        rd_val <= {23'h00_0000, in_use_r, work_bit_r};
      end else if (paddr == WBL_EVSRC_OFF) begin
        rd_val <= {16'h0000, evsrc_r};
      end else if (paddr == WBL_HWCFG_OFF) begin
        rd_val <= {29'h0000_0000, hwcfg_r};
      end else begin
        rd_val <= 32'h0000_0000;
      end
    end
  end

  // [R07] power-up pulse lasts exactly the first evaluation
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      pwrup_r <= 1'b1;
    end else if (eval_i) begin
      pwrup_r <= 1'b0;
    end
  end

  // source vector; unlisted codes and code 35 read as zero
  always_comb begin
    src_vec = 64'h0000_0000_0000_0000;
    // [R07] constants and power-up
    src_vec[WBL_SRC_OFF]   = 1'b0;
    src_vec[WBL_SRC_ON]    = 1'b1;
    src_vec[WBL_SRC_PWRUP] = pwrup_r;
    // [R08] event pins one to four
    for (int i = 0; i < WBL_NUM_EV; i++) begin
      src_vec[WBL_SRC_EV1 + i] = ev_sync_r[i];
    end
    // [R09] alarms and count alarm
    for (int i = 0; i < 3; i++) begin
      src_vec[WBL_SRC_ALM1 + i] = status_i.alarm[i];
    end
    src_vec[WBL_SRC_CNTALM] = |status_i.count_alarm;
    // [R10] output 1 masked when linear
    src_vec[WBL_SRC_OUT1] = status_i.ctrl_out[0] & ~hwcfg_r[WBL_HW_OUT1_LIN];
    // [R11] output 2 masked when absent or linear
    src_vec[WBL_SRC_OUT2] = status_i.ctrl_out[1] &
                            ~hwcfg_r[WBL_HW_OUT2_ABS] &
                            ~hwcfg_r[WBL_HW_OUT2_LIN];
    // [R12] errors and heater alarms
    src_vec[WBL_SRC_INERR]  = status_i.input_err;
    src_vec[WBL_SRC_RSPERR] = status_i.remote_setpoint_err;
    src_vec[WBL_SRC_HBURN]  = status_i.heater_burnout;
    src_vec[WBL_SRC_HSHORT] = status_i.heater_short;
    src_vec[WBL_SRC_HOVER]  = status_i.heater_overcurrent;
    // [R13] manual, reset, hold
    src_vec[WBL_SRC_MANUAL] = status_i.manual;
    src_vec[WBL_SRC_RESET]  = status_i.reset_mode;
    src_vec[WBL_SRC_HOLD]   = status_i.hold;
    // [R14] modes and run states
    src_vec[WBL_SRC_SPPROG]  = status_i.setpoint_prog;
    src_vec[WBL_SRC_SPREM]   = status_i.setpoint_remote;
    src_vec[WBL_SRC_SPFIX]   = status_i.setpoint_fixed;
    src_vec[WBL_SRC_ATUNE]   = status_i.autotuning;
    src_vec[WBL_SRC_RUN]     = status_i.run;
    src_vec[WBL_SRC_STANDBY] = status_i.standby;
    src_vec[WBL_SRC_WAIT]    = status_i.wait_state;
    // [R15] time signals, end, stage
    for (int i = 0; i < 2; i++) begin
      src_vec[WBL_SRC_TSIG1 + i] = status_i.time_sig[i];
    end
    src_vec[WBL_SRC_PEND]  = status_i.prog_end;
    src_vec[WBL_SRC_STAGE] = status_i.stage;
    // [R16] program and segment bits
    for (int i = 0; i < 3; i++) begin
      src_vec[WBL_SRC_PROG0 + i] = status_i.prog_num[i];
    end
    for (int i = 0; i < 5; i++) begin
      src_vec[WBL_SRC_SEG0 + i] = status_i.seg_num[i];
    end
    // [R17] feedback of last cycle's work bits
    for (int i = 0; i < WBL_NUM_WB; i++) begin
      src_vec[WBL_SRC_WB1 + i] = work_bit_r[i];
    end
  end

  // [R01] one evaluator per work bit
  // [R17] every selector sees the same code list
  for (genvar g = 0; g < WBL_NUM_WB; g++) begin : g_wb
    wbl_work_bit u_wb (
      .src_i    (src_vec),
      .cfg_i    (cfg_r[g]),
      .result_o (result[g])
    );
  end

  // [R23] all bits update together; feedback reads the old values
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      work_bit_r <= 8'h00;
    end else if (eval_i) begin
      work_bit_r <= result;
    end
  end

  // [R21] dot shown while any work bit is in use
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      in_use_r <= 1'b0;
    end else begin
      in_use_r <= 1'b0;
      for (int i = 0; i < WBL_NUM_WB; i++) begin
        if (cfg_r[i].op != WBL_OP_NONE) begin
          in_use_r <= 1'b1;
        end
      end
    end
  end

  // [R22] event data per event slot; out-of-range codes give zero
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      event_data_r <= 4'h0;
    end else begin
      for (int j = 0; j < WBL_NUM_EV; j++) begin
        logic [3:0] code;
        code = evsrc_r[j*4 +: 4];
        if (code >= WBL_EVD_EXT1 && code <= WBL_EVD_EXT4) begin
          event_data_r[j] <= ev_sync_r[2'(code - WBL_EVD_EXT1)];
        end else if (code >= WBL_EVD_WB1 && code <= WBL_EVD_WB8) begin
          event_data_r[j] <= work_bit_r[3'(code - WBL_EVD_WB1)];
        end else begin
          event_data_r[j] <= 1'b0;
        end
      end
    end
  end

  // [R20] work bits go out to output routing and status logic
  assign work_bits_o  = work_bit_r;
  assign event_data_o = event_data_r;
  assign in_use_o     = in_use_r;

endmodule
`default_nettype wire

// ### src/wbl_pkg.sv
// work bit logic evaluator: shared constants, codes and carriers
// assumes one 100 MHz clock and an APB register slave in front of it
package wbl_pkg;

  // sizes of the evaluator
  localparam int unsigned WBL_NUM_WB  = 8;
  localparam int unsigned WBL_NUM_IN  = 4;
  localparam int unsigned WBL_NUM_EV  = 4;
  localparam int unsigned WBL_SEL_W   = 6;
  localparam int unsigned WBL_SRC_W   = 64;
  localparam int unsigned WBL_EVSEL_W = 4;
  localparam int unsigned WBL_ADDR_W  = 8;

  // register byte offsets
  localparam logic [7:0] WBL_CFG_BASE  = 8'h00;
  localparam logic [7:0] WBL_CFG_LAST  = 8'h1c;
  localparam logic [7:0] WBL_STAT_OFF  = 8'h20;
  localparam logic [7:0] WBL_EVSRC_OFF = 8'h24;
  localparam logic [7:0] WBL_HWCFG_OFF = 8'h28;

  // field positions outside the config word
  localparam int unsigned WBL_STAT_INUSE_BIT = 8;
  localparam int unsigned WBL_HW_OUT1_LIN    = 0;
  localparam int unsigned WBL_HW_OUT2_ABS    = 1;
  localparam int unsigned WBL_HW_OUT2_LIN    = 2;

  // values after reset
  localparam logic [31:0] WBL_CFG_RST   = 32'h0000_0000;
  localparam logic [15:0] WBL_EVSRC_RST = 16'h0000;
  localparam logic [2:0]  WBL_HWCFG_RST = 3'h0;

  // operation types
  localparam logic [2:0] WBL_OP_NONE   = 3'h0;
  localparam logic [2:0] WBL_OP_ANDOR  = 3'h1;
  localparam logic [2:0] WBL_OP_ORAND  = 3'h2;
  localparam logic [2:0] WBL_OP_ANYOR  = 3'h3;
  localparam logic [2:0] WBL_OP_ALLAND = 3'h4;

  // input selector codes
  localparam int unsigned WBL_SRC_OFF     = 0;
  localparam int unsigned WBL_SRC_ON      = 1;
  localparam int unsigned WBL_SRC_PWRUP   = 2;
  localparam int unsigned WBL_SRC_EV1     = 3;
  localparam int unsigned WBL_SRC_ALM1    = 7;
  localparam int unsigned WBL_SRC_CNTALM  = 10;
  localparam int unsigned WBL_SRC_OUT1    = 11;
  localparam int unsigned WBL_SRC_OUT2    = 12;
  localparam int unsigned WBL_SRC_INERR   = 13;
  localparam int unsigned WBL_SRC_RSPERR  = 14;
  localparam int unsigned WBL_SRC_HBURN   = 15;
  localparam int unsigned WBL_SRC_HSHORT  = 16;
  localparam int unsigned WBL_SRC_HOVER   = 17;
  localparam int unsigned WBL_SRC_MANUAL  = 18;
  localparam int unsigned WBL_SRC_RESET   = 19;
  localparam int unsigned WBL_SRC_HOLD    = 20;
  localparam int unsigned WBL_SRC_SPPROG  = 21;
  localparam int unsigned WBL_SRC_SPREM   = 22;
  localparam int unsigned WBL_SRC_SPFIX   = 23;
  localparam int unsigned WBL_SRC_ATUNE   = 24;
  localparam int unsigned WBL_SRC_RUN     = 25;
  localparam int unsigned WBL_SRC_STANDBY = 26;
  localparam int unsigned WBL_SRC_WAIT    = 27;
  localparam int unsigned WBL_SRC_TSIG1   = 28;
  localparam int unsigned WBL_SRC_PEND    = 30;
  localparam int unsigned WBL_SRC_STAGE   = 31;
  localparam int unsigned WBL_SRC_PROG0   = 32;
  localparam int unsigned WBL_SRC_SEG0    = 36;
  localparam int unsigned WBL_SRC_WB1     = 41;

  // event data source codes
  localparam logic [3:0] WBL_EVD_EXT1 = 4'h1;
  localparam logic [3:0] WBL_EVD_EXT4 = 4'h4;
  localparam logic [3:0] WBL_EVD_WB1  = 4'h5;
  localparam logic [3:0] WBL_EVD_WB8  = 4'hc;

  // one work bit's setup, laid out as its register word
  typedef struct packed {
    logic [2:0]      op;
    logic            out_inv;
    logic [3:0]      in_inv;
    logic [3:0][5:0] sel;
  } wbl_cfg_t;

  // controller status feeding the selectors
  typedef struct packed {
    logic [2:0] alarm;
    logic [1:0] count_alarm;
    logic [1:0] ctrl_out;
    logic       input_err;
    logic       remote_setpoint_err;
    logic       heater_burnout;
    logic       heater_short;
    logic       heater_overcurrent;
    logic       manual;
    logic       reset_mode;
    logic       hold;
    logic       setpoint_prog;
    logic       setpoint_remote;
    logic       setpoint_fixed;
    logic       autotuning;
    logic       run;
    logic       standby;
    logic       wait_state;
    logic [1:0] time_sig;
    logic       prog_end;
    logic       stage;
    logic [2:0] prog_num;
    logic [4:0] seg_num;
  } wbl_status_t;

endpackage

// ### src/wbl_work_bit.sv
// one work bit: picks four inputs, inverts, combines, inverts the result
// assumes a source vector and a setup word that are stable in the cycle
`timescale 1ns/100ps
`default_nettype none
module wbl_work_bit (
  input  wire logic [63:0]       src_i,    // selectable signals by code
  input  wire wbl_pkg::wbl_cfg_t cfg_i,    // operation and selectors
  output logic                   result_o  // combined value, unregistered
);
  import wbl_pkg::*;

  logic [3:0] in_v;
  logic       raw;

  // [R18] per input inversion
  always_comb begin
    for (int i = 0; i < 4; i++) begin
      in_v[i] = src_i[cfg_i.sel[i]] ^ cfg_i.in_inv[i];
    end
  end

  // operation select; unknown types behave as no operation
  always_comb begin
    case (cfg_i.op)
      // [R03] and then or
      WBL_OP_ANDOR:  raw = (in_v[0] & in_v[1]) | (in_v[2] & in_v[3]);
      // [R04] or then and
      WBL_OP_ORAND:  raw = (in_v[0] | in_v[2]) & (in_v[1] | in_v[3]);
      // [R05] any input
      WBL_OP_ANYOR:  raw = |in_v;
      // [R06] all inputs
      WBL_OP_ALLAND: raw = &in_v;
      default:       raw = 1'b0;
    endcase
  end

  // [R02] no operation stays off
  // [R19] output inversion only for real operations
  assign result_o = (cfg_i.op >= WBL_OP_ANDOR && cfg_i.op <= WBL_OP_ALLAND) ?
                    (raw ^ cfg_i.out_inv) : 1'b0;

endmodule
`default_nettype wire

// ### test/wbl_evaluator_sva.sv
// checker for the work bit evaluator: apb answers and work bit timing
// assumes it sees only the evaluator's ports, attached by the bind below
`timescale 1ns/100ps
`default_nettype none
module wbl_evaluator_chk (
  input wire logic        clk_i,        // clock
  input wire logic        arst_n_i,     // async reset, active low
  input wire logic        psel,         // slave select
  input wire logic        penable,      // access phase
  input wire logic        pwrite,       // write when high
  input wire logic [7:0]  paddr,        // byte address
  input wire logic [31:0] pwdata,       // write data
  input wire logic        pready,       // ready
  input wire logic [31:0] prdata,       // read data
  input wire logic        pslverr,      // error
  input wire logic        eval_i,       // evaluation pulse
  input wire logic [3:0]  event_i,      // event pins
  input wire logic [7:0]  work_bits_o,  // work bits
  input wire logic [3:0]  event_data_o, // event data
  input wire logic        in_use_o      // in-use dot
);
  import wbl_pkg::*;
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!arst_n_i);
  logic bad_a;
  // address decode shared by the refusal checks
  assign bad_a = (paddr > WBL_HWCFG_OFF) || (paddr[1:0] != 2'b00);
  sequence s_rd_setup;
    psel && !penable && !pwrite;
  endsequence
  sequence s_cfg_on;
    psel && penable && pwrite && !bad_a && paddr <= WBL_CFG_LAST && pwdata[31:29] != 3'h0;
  endsequence
  chk_err_phase: assert property (pslverr |-> psel && penable)
    else $error("pslverr outside access phase");
  chk_err_unmapped: assert property (psel && penable && bad_a |-> pslverr)
    else $error("unmapped access not refused");
  chk_ready_access: assert property (psel && penable |-> pready)
    else $error("access phase without ready");
  chk_err_rdata: assert property (s_rd_setup ##0 bad_a |=> prdata == 32'h0000_0000)
    else $error("unmapped read returned data");
  chk_status_read: assert property (
    s_rd_setup ##0 paddr == WBL_STAT_OFF |=> prdata[8:0] == $past({in_use_o, work_bits_o}))
    else $error("status read disagrees with outputs");
  chk_bits_hold: assert property (!eval_i |=> $stable(work_bits_o))
    else $error("work bits moved without evaluation");
  chk_inuse_set: assert property (s_cfg_on |-> ##[1:2] in_use_o)
    else $error("in-use flag missing after op write");
  chk_evdata_quiet: assert property (
    (!eval_i && !(psel && pwrite) && $stable(event_i)) [*4] |=> $stable(event_data_o))
    else $error("event data moved with quiet sources");
endmodule
bind wbl_evaluator wbl_evaluator_chk u_chk (.clk_i(clk_i), .arst_n_i(arst_n_i), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
  .prdata(prdata), .pslverr(pslverr), .eval_i(eval_i), .event_i(event_i),
  .work_bits_o(work_bits_o), .event_data_o(event_data_o), .in_use_o(in_use_o));
`default_nettype wire

// ### test/wbl_evaluator_test.sv
// testbench for the work bit evaluator: apb setup, status and event stimulus
// assumes the checker is bound to the evaluator from its own file
`timescale 1ns/100ps
`default_nettype none
module wbl_evaluator_test;
  import wbl_pkg::*;
  logic        clk_i = 1'b0;
  logic        arst_n_i, psel, penable, pwrite, pready, pslverr, eval_i, in_use_o, last_err;
  logic [7:0]  paddr, work_bits_o, wb_exp;
  logic [31:0] pwdata, prdata, q;
  logic [31:0] cw [8];
  logic [3:0]  event_i, event_data_o;
  logic [$bits(wbl_status_t)-1:0] one_hot;
  wbl_status_t status_i;
  int          err_total, check_count;
  // code that selects each status bit, lsb first
  logic [5:0]  code_tab [34] = '{36, 37, 38, 39, 40, 32, 33, 34, 31, 30, 28, 29, 27, 26, 25,
    24, 23, 22, 21, 20, 19, 18, 17, 16, 15, 14, 13, 11, 12, 10, 10, 7, 8, 9};
  logic [7:0]  ta [3] = '{8'h2c, 8'h02, 8'h20};
  // 100 MHz clock
  always #5 clk_i = ~clk_i;
  wbl_evaluator DUT (.clk_i(clk_i), .arst_n_i(arst_n_i), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata),
    .pslverr(pslverr), .eval_i(eval_i), .event_i(event_i), .status_i(status_i),
    .work_bits_o(work_bits_o), .event_data_o(event_data_o), .in_use_o(in_use_o));
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      err_total++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  // one apb transfer, held until ready is seen; a hang ends the run
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int n;
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_i);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clk_i);
      n++;
    end while (pready !== 1'b1 && n < 16);
    if (n >= 16) begin
      err_total++;
      print_verdict();
    end
    q = prdata;
    last_err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk_i);
  endtask
  // one evaluation pulse; bits and event data settle within two edges
  task automatic run_eval();
    eval_i <= 1'b1;
    @(posedge clk_i);
    eval_i <= 1'b0;
    repeat (2) @(posedge clk_i);
  endtask
  function automatic logic [31:0] cfgw(input logic [2:0] op, input logic oi,
    input logic [3:0] ii, input logic [5:0] a, input logic [5:0] b);
    return {op, oi, ii, 6'd6, 6'd5, b, a};
  endfunction
  // expected work bit from one setup word and raw inputs
  function automatic logic model(input logic [31:0] w, input logic [3:0] v);
    logic [3:0] x;
    logic       r;
    x = v ^ w[27:24];
    case (w[31:29])
      3'h1: r = (x[0] & x[1]) | (x[2] & x[3]);
      3'h2: r = (x[0] | x[2]) & (x[1] | x[3]);
      3'h3: r = |x;
      3'h4: r = &x;
      default: return 1'b0;
    endcase
    return r ^ w[28];
  endfunction
  initial begin
    {arst_n_i, psel, penable, pwrite, eval_i} = '0;
    {paddr, pwdata, event_i, status_i} = '0;
    repeat (6) @(posedge clk_i);
    arst_n_i <= 1'b1;
    @(posedge clk_i);
    // every register starts cleared
    for (int i = 0; i < 11; i++) begin
      apb(1'b0, 8'(4 * i), 32'h0);
      check(q, 32'h0000_0000);
    end
    // power-up pulse, constants, inversion; c and d sit on low event pins
    apb(1'b1, 8'h00, cfgw(3'h4, 1'b0, 4'hc, 6'd2, 6'd1));
    apb(1'b1, 8'h04, cfgw(3'h4, 1'b0, 4'hc, 6'd1, 6'd1));
    apb(1'b1, 8'h08, cfgw(3'h4, 1'b1, 4'hc, 6'd0, 6'd1));
    apb(1'b1, 8'h0c, cfgw(3'h0, 1'b1, 4'hf, 6'd1, 6'd1));
    apb(1'b0, WBL_STAT_OFF, 32'h0);
    check(q, 32'h0000_0100);
    run_eval();
    check({24'h0, work_bits_o}, 32'h0000_0007);
    run_eval();
    check({24'h0, work_bits_o}, 32'h0000_0006);
    // every operation over all event pin patterns, eight bits at once
    for (int k = 0; k < 8; k++) begin
      cw[k] = cfgw(3'(k % 4 + 1), k[1] ^ k[2], k[2] ? 4'h9 : 4'h0, 6'd3, 6'd4);
      apb(1'b1, 8'(4 * k), cw[k]);
    end
    apb(1'b1, WBL_EVSRC_OFF, 32'h0000_c541);
    for (int p = 0; p < 16; p++) begin
      event_i <= 4'(p);
      repeat (3) @(posedge clk_i);
      run_eval();
      for (int k = 0; k < 8; k++) wb_exp[k] = model(cw[k], 4'(p));
      check({24'h0, work_bits_o}, {24'h0, wb_exp});
      check({28'h0, event_data_o}, {28'h0, wb_exp[7], wb_exp[0], 1'(p >> 3), 1'(p)});
    end
    event_i <= 4'h0;
    // each status source alone, then all others
    for (int i = 0; i < 34; i++) begin
      apb(1'b1, 8'h00, cfgw(3'h3, 1'b0, 4'h0, code_tab[i], 6'd0));
      for (int s = 0; s < 2; s++) begin
        one_hot = '0;
        one_hot[i] = 1'b1;
        status_i <= s ? ~one_hot : one_hot;
        run_eval();
        check({31'h0, work_bits_o[0]}, {31'h0, s == 0 || code_tab[i] == 6'd10});
      end
    end
    // output type masks control output codes; reserved code stays low
    status_i <= '1;
    for (int j = 0; j < 3; j++) begin
      apb(1'b1, WBL_HWCFG_OFF, 32'(1 << j));
      apb(1'b1, 8'h00, cfgw(3'h3, 1'b0, 4'h0, j == 0 ? 6'd11 : 6'd12, 6'd35));
      run_eval();
      check({31'h0, work_bits_o[0]}, 32'h0000_0000);
    end
    // feedback takes last cycle's bits; bit 8 toggles itself
    for (int k = 0; k < 8; k++) apb(1'b1, 8'(4 * k), 32'h0);
    run_eval();
    apb(1'b0, WBL_STAT_OFF, 32'h0);
    check(q, 32'h0000_0000);
    apb(1'b1, 8'h00, cfgw(3'h3, 1'b0, 4'hc, 6'd1, 6'd0));
    apb(1'b1, 8'h04, cfgw(3'h3, 1'b0, 4'h0, 6'd41, 6'd0));
    apb(1'b1, 8'h1c, cfgw(3'h4, 1'b1, 4'hc, 6'd48, 6'd1));
    run_eval();
    check({24'h0, work_bits_o}, 32'h0000_0081);
    run_eval();
    check({24'h0, work_bits_o}, 32'h0000_0003);
    // refused and read-only places leave state alone
    for (int j = 0; j < 3; j++) begin
      apb(1'b1, ta[j], 32'hffff_ffff);
      check({31'h0, last_err}, {31'h0, j < 2});
      apb(1'b0, ta[j], 32'h0);
      check(q, j < 2 ? 32'h0 : 32'h0000_0103);
    end
    // a second reset clears the setup again
    arst_n_i <= 1'b0;
    repeat (2) @(posedge clk_i);
    arst_n_i <= 1'b1;
    @(posedge clk_i);
    apb(1'b0, 8'h1c, 32'h0);
    check(q, 32'h0000_0000);
    print_verdict();
  end
endmodule
`default_nettype wire
